// ===== pkg/fcg_consts.vh
`ifndef FCG_CONSTS_VH
`define FCG_CONSTS_VH
// Clocks and timing
`define FCG_SYS_CLK_HZ     40000000
`define FCG_REF_HZ         1000000
`define FCG_PRINT_IDLE_NS  15000
`define FCG_DISP_STEP_MS   100
// Time base chain
`define FCG_TB_FIRST_DIV   1000
`define FCG_TB_DECADE_DIV  10
`define FCG_TB_STAGES      6
`define FCG_DIGITS         6
// Register byte offsets
`define FCG_ADR_CTRL       4'h0
`define FCG_ADR_DISP       4'h4
`define FCG_ADR_STATUS     4'h8
`define FCG_ADR_STORED     4'hC
// Control fields
`define FCG_MODE_LSB       0
`define FCG_MODE_MSB       2
`define FCG_RATIO_BIT      4
`define FCG_INFINITE_BIT   5
`define FCG_MRESET_BIT     8
`define FCG_DISP_MSB       6
`define FCG_DISP_RST       7'h0A
// Modes
`define FCG_MODE_OFF       3'h0
`define FCG_MODE_COUNT     3'h1
`define FCG_MODE_F1MS      3'h2
// Legend codes
`define FCG_LEG_NONE       4'h0
`define FCG_LEG_US         4'h1
`define FCG_LEG_MS         4'h2
`define FCG_LEG_S          4'h3
`define FCG_LEG_MHZ        4'h4
`define FCG_LEG_KHZ        4'h5
`endif

// ===== tb/fcg_control_asserts.sv
`timescale 1ns/1ps
module fcg_control_asserts #(
  parameter DIGITS = 6
) (
  input wire                sys_clk,
  input wire                rst,
  input wire                wb_stb_i,
  input wire                wb_cyc_i,
  input wire                wb_ack_o,
  input wire                rec_inhibit_pin,
  input wire [4*DIGITS-1:0] prn_digits,
  input wire [3:0]          prn_point_r,
  input wire [3:0]          prn_legend_r,
  input wire                prn_cmd_r,
  input wire                gate_lamp_r
);
  reg [9:0] low_r;
  reg [2:0] inh_r;
  reg       bcd_ok;
  integer   i;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Released time and inhibit run length
  always @(posedge sys_clk) begin
    low_r <= (rst || prn_cmd_r) ? 10'h000 : low_r + {9'h000, low_r != 10'h3FF};
    inh_r <= !rec_inhibit_pin ? 3'h0 : inh_r + {2'h0, inh_r != 3'h7};
  end
  always @* begin
    bcd_ok = 1'b1;
    for (i = 0; i < DIGITS; i = i + 1)
      if (prn_digits[4*i +: 4] > 4'h9) bcd_ok = 1'b0;
  end
  a_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_bcd_digits:
    assert property (bcd_ok) else $error("digit outside BCD");
  a_legend_code:
    assert property (prn_legend_r == 4'h0 || prn_legend_r == 4'h5) else $error("bad legend");
  a_point_range:
    assert property (prn_point_r <= 4'h5) else $error("bad point position");
  a_print_idle:
    assert property ($rose(prn_cmd_r) |-> low_r >= 10'h258) else $error("print idle too short");
  a_print_data:
    assert property ($rose(prn_cmd_r) |-> $stable(prn_digits) && !gate_lamp_r) else $error("print before store");
  a_inhibit_hold:
    assert property ($fell(prn_cmd_r) && !$past(wb_stb_i) && !$past(wb_stb_i, 2) |-> $past(inh_r) < 3'h4)
      else $error("reset while inhibited");
  a_reset_clear:
    assert property (disable iff (1'b0) rst |=> !prn_cmd_r && !gate_lamp_r && !wb_ack_o && prn_digits == 0)
      else $error("outputs not cleared by reset");
endmodule
bind fcg_control fcg_control_asserts #(.DIGITS(DIGITS)) i_fcg_control_asserts (
  .sys_clk(sys_clk), .rst(rst), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .rec_inhibit_pin(rec_inhibit_pin), .prn_digits(prn_digits), .prn_point_r(prn_point_r),
  .prn_legend_r(prn_legend_r), .prn_cmd_r(prn_cmd_r), .gate_lamp_r(gate_lamp_r));

// ===== tb/fcg_printer_model.sv
`timescale 1ns/1ps
module fcg_printer_model #(
  parameter HOLD = 100
) (
  input  wire        sys_clk,
  input  wire        prn_cmd,
  input  wire [3:0]  legend,
  input  wire [3:0]  point,
  input  wire [23:0] digits,
  output reg         inhibit_r,
  output reg  [31:0] record_r,
  output reg  [7:0]  count_r
);
  reg        cmd_d_r;
  reg [15:0] hold_r;
  initial begin
    inhibit_r = 1'b0;
    count_r = 8'h00;
    hold_r = 16'h0000;
    record_r = 32'h0000_0000;
  end
  always @(posedge sys_clk) begin
    cmd_d_r <= prn_cmd;
    if (prn_cmd && !cmd_d_r) begin
      record_r <= {legend, point, digits};
      count_r <= count_r + 8'h01;
      inhibit_r <= 1'b1;
      hold_r <= 16'(HOLD);
    end else if (hold_r != 16'h0000) begin
      hold_r <= hold_r - 16'h0001;
    end else begin
      inhibit_r <= 1'b0;
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
  fail_count = fail_count + 1; $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  reg         sys_clk, rst, we, stb, cyc, inp_a, inp_b;
  reg  [3:0]  adr;
  reg  [31:0] dat, q;
  reg  [23:0] d;
  reg  [5:0]  ph_r;
  wire [31:0] dat_o, rec;
  wire [23:0] digits;
  wire [3:0]  point, legend;
  wire [7:0]  recs;
  wire        ack, inh, cmd, gate;
  integer     fail_count, check_count, n;
  fcg_control #(.DIGITS(6), .DISP_STEP_CYC(20)) i_fcg_control (.sys_clk(sys_clk), .rst(rst),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb),
    .wb_cyc_i(cyc), .wb_ack_o(ack), .inp_a_pin(inp_a), .inp_b_pin(inp_b), .rec_inhibit_pin(inh),
    .prn_digits(digits), .prn_point_r(point), .prn_legend_r(legend), .prn_cmd_r(cmd), .gate_lamp_r(gate));
  fcg_printer_model #(.HOLD(100)) i_fcg_printer_model (.sys_clk(sys_clk), .prn_cmd(cmd), .legend(legend),
    .point(point), .digits(digits), .inhibit_r(inh), .record_r(rec), .count_r(recs));
  always #12.5 sys_clk = ~sys_clk;
  // Input A every 40 cycles, input B every 4
  always @(posedge sys_clk) begin
    ph_r <= (rst || ph_r == 6'h27) ? 6'h00 : ph_r + 6'h01;
    inp_b <= ph_r[1] & ~rst;
    inp_a <= (ph_r < 6'h14) & ~rst;
  end
  function integer bcd_val(input [23:0] x);
    integer k;
    begin
      bcd_val = 0;
      for (k = 5; k >= 0; k = k - 1) bcd_val = bcd_val * 10 + x[4*k +: 4];
    end
  endfunction
  task summarize;
    begin
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task hang;
    begin
      fail_count = fail_count + 1;
      $display("Error %0t: timeout", $time);
      summarize;
    end
  endtask
  task wb(input [3:0] a, input w, input [31:0] v);
    begin
      adr <= a; we <= w; dat <= v; cyc <= 1'b1; stb <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n = n + 1; end while (ack !== 1'b1 && n < 20);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (ack !== 1'b1) hang;
      @(posedge sys_clk);
    end
  endtask
  task wait_cmd(input v);
    begin
      n = 0;
      while (cmd !== v && n < 20000) begin @(posedge sys_clk); n = n + 1; end
      if (cmd !== v) hang;
    end
  endtask
  task meas;
    begin
      wait_cmd(1'b1);
      `CHK(gate, 1'b0)
      `CHK(bcd_val(digits) >= 99 && bcd_val(digits) <= 101, 1'b1)
      `CHK(point, 4'h0)
      `CHK(legend, 4'h0)
      @(posedge sys_clk);
      `CHK(rec, {4'h0, 4'h0, digits})
    end
  endtask
  initial begin
    sys_clk = 0; rst = 1; we = 0; stb = 0; cyc = 0; adr = 0; dat = 0;
    fail_count = 0; check_count = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wb(4'h4, 0, 0); `CHK(q, 32'h0000_000A)
    wb(4'h2, 1, 32'hFFFF_FFFF); wb(4'h2, 0, 0); `CHK(q, 32'h0000_0000)
    wb(4'h4, 1, 0); wb(4'h4, 0, 0); `CHK(q, 32'h0000_0001)
    wb(4'h0, 1, 32'h0000_0001); repeat (400) @(posedge sys_clk);
    `CHK(gate, 1'b1)
    d = digits; repeat (80) @(posedge sys_clk);
    `CHK(digits > d && cmd === 1'b0, 1'b1)
    wb(4'h0, 1, 0); repeat (80) @(posedge sys_clk); d = digits;
    `CHK(gate, 1'b0)
    repeat (80) @(posedge sys_clk); `CHK(digits, d)
    wb(4'h0, 1, 32'h0000_0112); meas;
    repeat (60) @(posedge sys_clk); `CHK(cmd, 1'b1)
    wait_cmd(1'b0); `CHK(n >= 40 && n <= 85, 1'b1)
    meas; `CHK(recs, 8'h02)
    wb(4'h0, 1, 32'h0000_0032); repeat (300) @(posedge sys_clk);
    `CHK(cmd, 1'b1)
    wb(4'h8, 0, 0); `CHK(q, 32'h0000_0086)
    wb(4'hC, 0, 0); `CHK(q, {8'h00, digits})
    d = digits; wb(4'h0, 1, 32'h0000_0132); wait_cmd(1'b0);
    `CHK(n <= 4, 1'b1)
    `CHK(digits, d)
    `CHK(gate, 1'b0)
    wb(4'h0, 1, 32'h0000_0003); repeat (2) @(posedge sys_clk);
    `CHK(legend, 4'h5)
    `CHK(point, 4'h1)
    summarize;
  end
endmodule

// ===== verilog/fcg_control.v
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "fcg_consts.vh"
// Notes on behaviour
// RULE_01 - Each decade leaves as 1-2-4-8 BCD, units digit rightmost.
// RULE_02 - Extra BCD digits carry decimal point position and unit legend.
// RULE_03 - Legend codes: 1 us, 2 ms, 3 s, 4 MHz, 5 kHz.
// RULE_04 - Decimal point digit counts position from the rightmost digit.
// RULE_05 - Printer prints legend, then decimal point, then data digits.
// RULE_06 - Print command steps at cycle end; released level lasts over 15 us.
// RULE_07 - Held recorder inhibit suppresses automatic reset until released.
// RULE_08 - Frequency gate times from 1 ms to 100 s in decades.
// RULE_09 - Totalize: run opens the gate, hold closes it.
// RULE_10 - Frequency: gate opens and closes on selected time base events.
// RULE_11 - At stop, counters transfer into storage once per measurement.
// RULE_12 - Gate closing stops counting, stores, and starts display timer.
// RULE_13 - Display time 0.1 s to 10 s, then automatic reset. The 7-bit setting here accepts up to 12.7 s.
// RULE_14 - Infinite display never auto-resets; manual reset needed.
// RULE_15 - Any reset begins a new measurement cycle by itself.
// RULE_16 - Totalize keeps gate enabled and store active continuously.
// RULE_17 - Time base dividers run continuously; mode only selects output.
// RULE_18 - Ratio uses secondary input instead of reference for time base.
// RULE_19 - Decimal point follows gate time so reading is in kHz.
// RULE_20 - First event sets gate, next clears it; latch then blocks gating.
// RULE_21 - Manual reset overrides everything and resets at once.
// RULE_22 - Reset clears counters and gate but keeps stored reading. In totalize the continuous store loads the cleared count a cycle after.
// RULE_23 - Print command follows completion of the same measurement's store.
module fcg_control #(
  parameter DIGITS        = `FCG_DIGITS,
  parameter DISP_STEP_CYC = `FCG_DISP_STEP_MS * (`FCG_SYS_CLK_HZ / 1000)
) (
  input  wire                sys_clk,
  input  wire                rst,
  input  wire [3:0]          wb_adr_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  input  wire                wb_we_i,
  input  wire [3:0]          wb_sel_i,
  input  wire                wb_stb_i,
  input  wire                wb_cyc_i,
  output reg                 wb_ack_o,
  input  wire                inp_a_pin,
  input  wire                inp_b_pin,
  input  wire                rec_inhibit_pin,
  output wire [4*DIGITS-1:0] prn_digits,
  output reg  [3:0]          prn_point_r,
  output reg  [3:0]          prn_legend_r,
  output reg                 prn_cmd_r,
  output reg                 gate_lamp_r
);
  localparam integer REF_DIV   = `FCG_SYS_CLK_HZ / `FCG_REF_HZ;
  localparam integer IDLE_CYC  = (`FCG_PRINT_IDLE_NS * (`FCG_SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam [1:0]   ST_ARM    = 2'h0;
  localparam [1:0]   ST_GATE   = 2'h1;
  localparam [1:0]   ST_DISP   = 2'h2;

  // Gate time index of a frequency mode
  function [2:0] fcg_tb_index;
    input [2:0] mode;
    begin
      fcg_tb_index = mode - `FCG_MODE_F1MS;
    end
  endfunction

  reg  [2:0]  a_sync_r;
  reg  [2:0]  b_sync_r;
  reg  [1:0]  inh_sync_r;
  reg  [5:0]  ref_cnt_r;
  reg         int_tick_r;
  reg  [2:0]  mode_r;
  reg         ratio_r;
  reg         infinite_r;
  reg  [6:0]  disp_time_r;
  reg         mrst_r;
  reg         auto_rst_r;
  reg         clr_r;
  reg  [1:0]  state_r;
  reg         store_r;
  reg         print_pend_r;
  reg  [9:0]  idle_cnt_r;
  reg  [22:0] step_cnt_r;
  reg  [6:0]  disp_cnt_r;
  wire [`FCG_TB_STAGES-1:0] tb_evt;
  wire        a_rise   = a_sync_r[1] & ~a_sync_r[2];
  wire        b_rise   = b_sync_r[1] & ~b_sync_r[2];
  wire        freq     = (mode_r >= `FCG_MODE_F1MS);
  wire        totalize = (mode_r == `FCG_MODE_COUNT) || (mode_r == `FCG_MODE_OFF);
  wire        sel_evt  = freq && tb_evt[fcg_tb_index(mode_r)];
  wire        meas_rst = mrst_r | auto_rst_r;
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        idle_ok  = (idle_cnt_r >= IDLE_CYC);
  wire        disp_end = (disp_cnt_r >= disp_time_r);
  // RULE_18 ratio time base
  wire        tb_tick  = ratio_r ? b_rise : int_tick_r;

  // Pin synchronisers
  always @(posedge sys_clk) begin
    if (rst) begin
      a_sync_r   <= 3'h0;
      b_sync_r   <= 3'h0;
      inh_sync_r <= 2'h0;
    end else begin
      a_sync_r   <= {a_sync_r[1:0], inp_a_pin};
      b_sync_r   <= {b_sync_r[1:0], inp_b_pin};
      inh_sync_r <= {inh_sync_r[0], rec_inhibit_pin};
    end
  end

  // RULE_17 free running reference
  always @(posedge sys_clk) begin
    if (rst) begin
      ref_cnt_r  <= 6'h00;
      int_tick_r <= 1'b0;
    end else begin
      int_tick_r <= (ref_cnt_r == REF_DIV - 6'h01);
      ref_cnt_r  <= (ref_cnt_r == REF_DIV - 6'h01) ? 6'h00 : ref_cnt_r + 6'h01;
    end
  end

  // RULE_08 decade gate times
  fcg_timebase u_tb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tb_tick),
    .evt_r   (tb_evt)
  );

  // RULE_01 BCD count chain
  fcg_decades #(
    .DIGITS (DIGITS)
  ) u_dec (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clr      (clr_r),
    .inc      (gate_lamp_r & a_rise),
    .store    (store_r | (totalize & ~clr_r)),
    .stored_r (prn_digits)
  );

  // Register bus slave
  always @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      mode_r      <= `FCG_MODE_OFF;
      ratio_r     <= 1'b0;
      infinite_r  <= 1'b0;
      disp_time_r <= `FCG_DISP_RST;
      mrst_r      <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      mrst_r   <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == `FCG_ADR_CTRL) begin
          if (wb_sel_i[0]) begin
            mode_r     <= wb_dat_i[`FCG_MODE_MSB:`FCG_MODE_LSB];
            ratio_r    <= wb_dat_i[`FCG_RATIO_BIT];
            infinite_r <= wb_dat_i[`FCG_INFINITE_BIT];
          end
          // RULE_21 manual reset request
          if (wb_sel_i[1]) begin
            mrst_r <= wb_dat_i[`FCG_MRESET_BIT];
          end
        end else if (wb_adr_i == `FCG_ADR_DISP && wb_sel_i[0]) begin
          // RULE_13 display time setting
          disp_time_r <= (wb_dat_i[`FCG_DISP_MSB:0] == 7'h00) ? 7'h01 : wb_dat_i[`FCG_DISP_MSB:0];
        end
      end else if (wb_req) begin
        case (wb_adr_i)
          `FCG_ADR_CTRL: begin
            wb_dat_o <= {26'h000_0000, infinite_r, ratio_r, 1'b0, mode_r};
          end
          `FCG_ADR_DISP: begin
            wb_dat_o <= {25'h000_0000, disp_time_r};
          end
          `FCG_ADR_STATUS: begin
            wb_dat_o <= {24'h00_0000, state_r, 1'b0, inh_sync_r[1], print_pend_r,
                         prn_cmd_r, state_r == ST_DISP, gate_lamp_r};
          end
          `FCG_ADR_STORED: begin
            wb_dat_o <= {{(32 - 4 * DIGITS){1'b0}}, prn_digits};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Measurement sequencer
  always @(posedge sys_clk) begin
    if (rst) begin
      state_r     <= ST_ARM;
      gate_lamp_r <= 1'b0;
      store_r     <= 1'b0;
      clr_r       <= 1'b0;
      auto_rst_r  <= 1'b0;
      step_cnt_r  <= 23'h00_0000;
      disp_cnt_r  <= 7'h00;
    end else begin
      store_r    <= 1'b0;
      auto_rst_r <= 1'b0;
      clr_r      <= 1'b0;
      if (meas_rst) begin
        // RULE_22 counters and gate cleared, storage kept in frequency modes
        // RULE_15 reset rearms the next cycle
        state_r     <= ST_ARM;
        gate_lamp_r <= 1'b0;
        clr_r       <= 1'b1;
        step_cnt_r  <= 23'h00_0000;
        disp_cnt_r  <= 7'h00;
      end else begin
        case (state_r)
          ST_ARM: begin
            if (freq) begin
              // RULE_10 start event opens gate
              // RULE_20 first event sets gate
              if (sel_evt) begin
                gate_lamp_r <= 1'b1;
                state_r     <= ST_GATE;
              end else begin
                gate_lamp_r <= 1'b0;
              end
            end else begin
              // RULE_09 totalize run or hold
              // RULE_16 gate follows mode
              gate_lamp_r <= (mode_r == `FCG_MODE_COUNT);
            end
          end
          ST_GATE: begin
            if (!freq) begin
              gate_lamp_r <= 1'b0;
              state_r     <= ST_ARM;
            end else if (sel_evt) begin
              // RULE_12 close, store, start timer
              // RULE_11 transfer at stop
              gate_lamp_r <= 1'b0;
              store_r     <= 1'b1;
              state_r     <= ST_DISP;
            end
          end
          ST_DISP: begin
            // RULE_20 display latch blocks gating
            if (!disp_end) begin
              if (step_cnt_r == DISP_STEP_CYC - 1) begin
                step_cnt_r <= 23'h00_0000;
                disp_cnt_r <= disp_cnt_r + 7'h01;
              end else begin
                step_cnt_r <= step_cnt_r + 23'h00_0001;
              end
            end else if (!infinite_r && !inh_sync_r[1] && !print_pend_r) begin
              // RULE_13 auto reset at end
              // RULE_14 none when infinite
              // RULE_07 inhibit holds off reset
              auto_rst_r <= 1'b1;
            end
          end
          default: begin
            state_r <= ST_ARM;
          end
        endcase
      end
    end
  end

  // Printer side
  always @(posedge sys_clk) begin
    if (rst) begin
      prn_cmd_r    <= 1'b0;
      print_pend_r <= 1'b0;
      idle_cnt_r   <= 10'h000;
      prn_point_r  <= 4'h0;
      prn_legend_r <= `FCG_LEG_NONE;
    end else begin
      // RULE_02 point and legend digits
      // RULE_19 point follows gate time
      // RULE_04 counted from the right
      prn_point_r <= freq ? {1'b0, fcg_tb_index(mode_r)} : 4'h0;
      // RULE_03 legend code
      prn_legend_r <= (freq && !ratio_r) ? `FCG_LEG_KHZ : `FCG_LEG_NONE;
      // RULE_06 released level lasts long enough
      if (prn_cmd_r) begin
        idle_cnt_r <= 10'h000;
      end else if (!idle_ok) begin
        idle_cnt_r <= idle_cnt_r + 10'h001;
      end
      if (meas_rst) begin
        prn_cmd_r    <= 1'b0;
        print_pend_r <= 1'b0;
      end else if (store_r) begin
        print_pend_r <= 1'b1;
      end else if (print_pend_r && idle_ok) begin
        // RULE_23 print after store completed
        prn_cmd_r    <= 1'b1;
        print_pend_r <= 1'b0;
      end
    end
  end
endmodule

// ===== verilog/fcg_decades.v
`timescale 1ns/1ps
`include "fcg_consts.vh"
module fcg_decades #(
  parameter DIGITS = `FCG_DIGITS
) (
  input  wire                sys_clk,
  input  wire                rst,
  input  wire                clr,
  input  wire                inc,
  input  wire                store,
  output reg  [4*DIGITS-1:0] stored_r
);
  wire [4*DIGITS-1:0] count;
  wire [DIGITS:0]     carry;
  assign carry[0] = inc;
  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_dec
      reg [3:0] dig_r;
      assign count[4*i+3:4*i] = dig_r;
      assign carry[i+1] = carry[i] && (dig_r == 4'h9);
      always @(posedge sys_clk) begin
        if (rst || clr) begin
          dig_r <= 4'h0;
        end else if (carry[i]) begin
          dig_r <= (dig_r == 4'h9) ? 4'h0 : dig_r + 4'h1;
        end
      end
    end
  endgenerate
  always @(posedge sys_clk) begin
    if (rst) begin
      stored_r <= {4*DIGITS{1'b0}};
    end else if (store) begin
      stored_r <= count;
    end
  end
endmodule

// ===== verilog/fcg_timebase.v
`timescale 1ns/1ps
`include "fcg_consts.vh"
module fcg_timebase #(
  parameter FIRST_DIV  = `FCG_TB_FIRST_DIV,
  parameter DECADE_DIV = `FCG_TB_DECADE_DIV,
  parameter STAGES     = `FCG_TB_STAGES
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              tick,
  output reg  [STAGES-1:0] evt_r
);
  wire [STAGES:0] carry;
  assign carry[0] = tick;
  genvar i;
  generate
    for (i = 0; i < STAGES; i = i + 1) begin : g_stage
      localparam integer LAST = (i == 0) ? FIRST_DIV - 1 : DECADE_DIV - 1;
      reg [9:0] cnt_r;
      assign carry[i+1] = carry[i] && (cnt_r == LAST);
      always @(posedge sys_clk) begin
        if (rst) begin
          cnt_r <= 10'h000;
        end else if (carry[i]) begin
          cnt_r <= (cnt_r == LAST) ? 10'h000 : cnt_r + 10'h001;
        end
      end
    end
  endgenerate
  always @(posedge sys_clk) begin
    if (rst) begin
      evt_r <= {STAGES{1'b0}};
    end else begin
      evt_r <= carry[STAGES:1];
    end
  end
endmodule
